// >>> design/sat_translator.v
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "sat_consts.vh"
// Behaviour
// RULE_01: Sixteen 8-bit space-number table entries
// RULE_02: Function code indexes table each bus cycle
// RULE_03: Space number compared against all descriptors
// RULE_04: Unmatched access asserts fault output
// RULE_05: A8-A23 translated into upper physical bits
// RULE_06: A1-A7 bypass translation unchanged
// RULE_07: Segment size from low mask don't-cares
// RULE_08: Segment bases aligned to segment size
// RULE_09: Master drives 3-bit function code
// RULE_10: Fourth code line selects second eight
// RULE_11: Single master holds fourth line low
// RULE_12: Segments can be write protected
// RULE_13: Access to chosen segment raises interrupt
// RULE_14: Software direct logical-to-physical translation
// RULE_15: Descriptor holds bases, masks, space, status
// RULE_16: Range match on mask-one bits only
// RULE_17: Physical bits from base where mask one
// RULE_18: Space match on space-mask-one bits
// RULE_19: Write to protected segment is violation
// RULE_20: Hit needs enable, range and space
module sat_translator (
    input  wire        clock,
    input  wire        arst_n,
    input  wire        cycle_strobe,
    input  wire        cycle_write,
    input  wire [2:0]  space_code_lines,
    input  wire        fourth_space_code_line,
    input  wire [23:1] logical_address,
    output reg  [15:0] translated_upper_bits,
    output reg  [6:0]  passthrough_low_bits,
    output reg         phys_valid,
    output reg         fault,
    output reg         irq_out,
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [15:0] reg_rdata
);

    // Two-stage synchronisers for the bus pins
    reg         s1_strobe_r;
    reg         s2_strobe_r;
    reg         s1_write_r;
    reg         s2_write_r;
    reg  [3:0]  s1_code_r;
    reg  [3:0]  s2_code_r;
    reg  [23:1] s1_addr_r;
    reg  [23:1] s2_addr_r;

    // Software-visible state
    reg  [7:0]  space_number_table [0:15];
    reg  [4:0]  dptr_r;
    reg  [15:0] tr_addr_r;
    reg  [7:0]  tr_space_r;
    reg         tr_go_r;
    reg  [15:0] tr_result_r;
    reg         tr_done_r;
    reg         tr_hit_r;
    reg         irq_en_r;

    // Match network
    wire [7:0]  task_space_number;
    wire [7:0]  sel_space;
    wire [15:0] sel_upper;
    wire [31:0] hit_vec;
    // Per-descriptor results, flattened one slot per descriptor
    wire [511:0] pa_flat;
    wire [511:0] lb_flat;
    wire [511:0] lm_flat;
    wire [511:0] pb_flat;
    wire [255:0] sn_flat;
    wire [255:0] sm_flat;
    wire [255:0] st_flat;
    wire [31:0] ip_vec;
    reg  [31:0] win_vec;
    reg  [15:0] win_pa;
    reg         win_wp;
    reg         any_hit;
    // Cycle qualifiers
    wire        bus_cycle;
    wire        violation;
    wire        good_access;
    wire        tr_run;
    // Loop index of the winner search
    integer     k;

    // Fourth line extends the index to sixteen entries
    assign task_space_number = space_number_table[s2_code_r]; // RULE_02 RULE_10
    assign bus_cycle   = s2_strobe_r;
    // Bus cycle owns the matcher; software translation waits for idle
    assign tr_run      = tr_go_r & ~bus_cycle;
    assign sel_upper   = bus_cycle ? s2_addr_r[23:8] : tr_addr_r;
    assign sel_space   = bus_cycle ? task_space_number : tr_space_r;
    assign violation   = bus_cycle & any_hit & s2_write_r & win_wp; // RULE_19 RULE_12
    assign good_access = bus_cycle & any_hit & ~violation;

    // Pin synchronisers; first stage feeds only the second
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s1_strobe_r <= 1'b0;
            s2_strobe_r <= 1'b0;
            s1_write_r  <= 1'b0;
            s2_write_r  <= 1'b0;
            s1_code_r   <= 4'h0;
            s2_code_r   <= 4'h0;
            s1_addr_r   <= 23'h000000;
            s2_addr_r   <= 23'h000000;
        end else begin
            s1_strobe_r <= cycle_strobe;
            s2_strobe_r <= s1_strobe_r;
            s1_write_r  <= cycle_write;
            s2_write_r  <= s1_write_r;
            s1_code_r   <= {fourth_space_code_line, space_code_lines}; // RULE_09 RULE_11
            s2_code_r   <= s1_code_r;
            // Address bits may settle a cycle apart; the master holds them
            // steady for at least three edges so the skew never shows
            s1_addr_r   <= logical_address;
            s2_addr_r   <= s1_addr_r;
        end
    end

    // Space-number table, one entry per function code
    genvar gs;
    generate
        for (gs = 0; gs < `SAT_NUM_SPACES; gs = gs + 1) begin : g_space
            // Offset worked out wide, then cut to the address width
            localparam integer OFF_I = `SAT_OFF_SPACE_BASE + gs;
            localparam [7:0]   OFF   = OFF_I[7:0];
            always @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    space_number_table[gs] <= `SAT_FIELD8_RST;
                end else if (reg_write && reg_addr == OFF) begin
                    space_number_table[gs] <= reg_wdata[7:0]; // RULE_01
                end
            end
        end
    endgenerate

    // Descriptors: six registers each, nine bytes of state
    genvar gi;
    generate
        for (gi = 0; gi < `SAT_NUM_DESC; gi = gi + 1) begin : g_desc
            // Descriptor 0 leaves reset enabled as a one-to-one map
            localparam integer GI_I  = gi;
            localparam [4:0] IDX     = GI_I[4:0];
            localparam [7:0] ST_INIT = (gi == 0) ? `SAT_ST_RST0 : `SAT_ST_RST;
            reg  [15:0] lb_r;
            reg  [15:0] lm_r;
            reg  [15:0] pb_r;
            reg  [7:0]  sn_r;
            reg  [7:0]  sm_r;
            reg  [7:0]  st_r;
            reg  [7:0]  st_nxt;
            wire        sel;
            wire        acc;

            // Pointer picks the fields the port reaches; only the winner counts
            assign sel = (dptr_r == IDX);
            assign acc = good_access & win_vec[gi];

            // Field loads through the descriptor pointer
            always @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    lb_r <= `SAT_FIELD16_RST;
                    lm_r <= `SAT_FIELD16_RST;
                    pb_r <= `SAT_FIELD16_RST;
                    sn_r <= `SAT_FIELD8_RST;
                    sm_r <= `SAT_FIELD8_RST;
                end else if (reg_write && sel) begin
                    if (reg_addr == `SAT_OFF_LBASE) begin
                        lb_r <= reg_wdata; // RULE_15
                    end
                    if (reg_addr == `SAT_OFF_LMASK) begin
                        lm_r <= reg_wdata;
                    end
                    if (reg_addr == `SAT_OFF_PBASE) begin
                        pb_r <= reg_wdata;
                    end
                    // Space mask rides in the high byte
                    if (reg_addr == `SAT_OFF_SPACE_NUM) begin
                        sn_r <= reg_wdata[7:0];
                        sm_r <= reg_wdata[15:8];
                    end
                end
            end

            // Status: software write first, hardware sets on top so they win
            always @* begin
                st_nxt = st_r;
                if (reg_write && sel && reg_addr == `SAT_OFF_STATUS) begin
                    st_nxt = reg_wdata[7:0] & `SAT_ST_WMASK;
                end
                if (acc) begin
                    st_nxt[`SAT_ST_USED] = 1'b1;
                    st_nxt[`SAT_ST_MOD]  = st_nxt[`SAT_ST_MOD] | s2_write_r;
                    st_nxt[`SAT_ST_IP]   = st_nxt[`SAT_ST_IP] | st_r[`SAT_ST_IRQ]; // RULE_13
                end
                // A disabled segment never holds a pending interrupt
                if (!st_nxt[`SAT_ST_EN]) begin
                    st_nxt[`SAT_ST_IP] = 1'b0;
                end
            end

            // Status register
            always @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    st_r <= ST_INIT;
                end else begin
                    st_r <= st_nxt;
                end
            end

            // Matcher sees bus-cycle or software inputs through the shared select
            sat_descriptor u_match (
                .logical_segment_base  (lb_r),
                .logical_match_mask    (lm_r),
                .physical_segment_base (pb_r),
                .desc_space_number     (sn_r),
                .space_number_mask     (sm_r),
                .seg_enable            (st_r[`SAT_ST_EN]),
                .logical_upper         (sel_upper),
                .task_space_number     (sel_space),
                .hit                   (hit_vec[gi]),
                .phys_upper            (pa_flat[gi*16 +: 16])
            ); // RULE_03 RULE_05

            // Flattened copies feed the read mux and the winner pick
            assign lb_flat[gi*16 +: 16] = lb_r;
            assign lm_flat[gi*16 +: 16] = lm_r;
            assign pb_flat[gi*16 +: 16] = pb_r;
            assign sn_flat[gi*8 +: 8]   = sn_r;
            assign sm_flat[gi*8 +: 8]   = sm_r;
            assign st_flat[gi*8 +: 8]   = st_r;
            assign ip_vec[gi]           = st_r[`SAT_ST_IP];
        end
    endgenerate

    // Lowest-numbered hit wins when segments overlap
    always @* begin
        win_vec = 32'h00000000;
        win_pa  = 16'h0000;
        win_wp  = 1'b0;
        any_hit = 1'b0;
        for (k = 0; k < `SAT_NUM_DESC; k = k + 1) begin
            // Later hits are ignored once any_hit is set
            if (hit_vec[k] && !any_hit) begin
                any_hit    = 1'b1;
                win_vec[k] = 1'b1;
                win_pa     = pa_flat[k*16 +: 16];
                win_wp     = st_flat[k*8 + `SAT_ST_WP];
            end
        end
    end

    // Valid, fault and upper bits follow the synchronised cycle strobe; low bits follow the address
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            translated_upper_bits <= 16'h0000;
            passthrough_low_bits  <= 7'h00;
            phys_valid            <= 1'b0;
            fault                 <= 1'b0;
            irq_out               <= 1'b0;
        end else begin
            passthrough_low_bits  <= s2_addr_r[7:1]; // RULE_06
            translated_upper_bits <= good_access ? win_pa : 16'h0000; // RULE_05 RULE_20
            phys_valid            <= good_access;
            fault                 <= bus_cycle & ~good_access; // RULE_04 RULE_19
            // Level: stays up until every pending bit or the enable clears
            irq_out               <= irq_en_r & (|ip_vec); // RULE_13
        end
    end

    // Control registers and the direct translation service
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dptr_r      <= 5'h00;
            tr_addr_r   <= 16'h0000;
            tr_space_r  <= 8'h00;
            tr_go_r     <= 1'b0;
            tr_result_r <= 16'h0000;
            tr_done_r   <= 1'b0;
            tr_hit_r    <= 1'b0;
            irq_en_r    <= 1'b0;
        end else begin
            // Upper pointer bits are dropped; 32 descriptors only
            if (reg_write && reg_addr == `SAT_OFF_DPTR) begin
                dptr_r <= reg_wdata[4:0];
            end
            if (reg_write && reg_addr == `SAT_OFF_TR_SPACE) begin
                tr_space_r <= reg_wdata[7:0];
            end
            // Only the enable is writable; the other global bits are status
            if (reg_write && reg_addr == `SAT_OFF_GLOBAL) begin
                irq_en_r <= reg_wdata[`SAT_GL_IRQ_EN];
            end
            // Result does not touch segment status bits
            if (tr_run) begin
                tr_go_r     <= 1'b0;
                tr_done_r   <= 1'b1;
                tr_hit_r    <= any_hit;
                tr_result_r <= any_hit ? win_pa : 16'h0000; // RULE_14
            end
            // A new request restarts the service and clears done
            if (reg_write && reg_addr == `SAT_OFF_TR_ADDR) begin
                tr_addr_r <= reg_wdata;
                tr_go_r   <= 1'b1;
                tr_done_r <= 1'b0;
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            // The space table fills the offsets below the pointer
            if (reg_addr < `SAT_OFF_DPTR) begin
                reg_rdata <= {8'h00, space_number_table[reg_addr[3:0]]};
            end else begin
                case (reg_addr)
                    `SAT_OFF_DPTR:      reg_rdata <= {11'h000, dptr_r};
                    `SAT_OFF_LBASE:     reg_rdata <= lb_flat[dptr_r*16 +: 16];
                    `SAT_OFF_LMASK:     reg_rdata <= lm_flat[dptr_r*16 +: 16];
                    `SAT_OFF_PBASE:     reg_rdata <= pb_flat[dptr_r*16 +: 16];
                    `SAT_OFF_SPACE_NUM: reg_rdata <= {sm_flat[dptr_r*8 +: 8],
                                                      sn_flat[dptr_r*8 +: 8]};
                    `SAT_OFF_STATUS:    reg_rdata <= {8'h00, st_flat[dptr_r*8 +: 8]};
                    `SAT_OFF_TR_ADDR:   reg_rdata <= tr_addr_r;
                    `SAT_OFF_TR_SPACE:  reg_rdata <= {8'h00, tr_space_r};
                    `SAT_OFF_TR_RESULT: reg_rdata <= tr_result_r;
                    `SAT_OFF_GLOBAL:    reg_rdata <= {12'h000, (|ip_vec), irq_en_r,
                                                      tr_hit_r, tr_done_r};
                    default:            reg_rdata <= 16'h0000;
                endcase
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // sat_translator

// >>> design/sat_consts.vh
`ifndef SAT_CONSTS_VH
`define SAT_CONSTS_VH

// Geometry
`define SAT_NUM_DESC        32
`define SAT_NUM_SPACES      16
`define SAT_ADDR_W          8
`define SAT_DATA_W          16

// Register offsets
`define SAT_OFF_SPACE_BASE  8'h00
`define SAT_OFF_DPTR        8'h10
`define SAT_OFF_LBASE       8'h11
`define SAT_OFF_LMASK       8'h12
`define SAT_OFF_PBASE       8'h13
`define SAT_OFF_SPACE_NUM   8'h14
`define SAT_OFF_STATUS      8'h15
`define SAT_OFF_TR_ADDR     8'h16
`define SAT_OFF_TR_SPACE    8'h17
`define SAT_OFF_TR_RESULT   8'h18
`define SAT_OFF_GLOBAL      8'h19

// Segment status bit positions
`define SAT_ST_EN           0
`define SAT_ST_WP           1
`define SAT_ST_MOD          2
`define SAT_ST_IP           3
`define SAT_ST_IRQ          4
`define SAT_ST_USED         7
`define SAT_ST_WMASK        8'h9f

// Global register bit positions
`define SAT_GL_DONE         0
`define SAT_GL_HIT          1
`define SAT_GL_IRQ_EN       2
`define SAT_GL_IRQ_ANY      3

// Reset values
`define SAT_ST_RST0         8'h01
`define SAT_ST_RST          8'h00
`define SAT_FIELD16_RST     16'h0000
`define SAT_FIELD8_RST      8'h00

`endif

// >>> design/sat_descriptor.v
`timescale 1ns/100ps
// One segment matcher: range match, space match and physical address forming
module sat_descriptor (
    input  wire [15:0] logical_segment_base,
    input  wire [15:0] logical_match_mask,
    input  wire [15:0] physical_segment_base,
    input  wire [7:0]  desc_space_number,
    input  wire [7:0]  space_number_mask,
    input  wire        seg_enable,
    input  wire [15:0] logical_upper,
    input  wire [7:0]  task_space_number,
    output wire        hit,
    output wire [15:0] phys_upper
);

    wire range_ok;
    wire space_ok;

    // Zero mask bits are don't-care, so low zeros set the segment size
    assign range_ok = ((logical_upper ^ logical_segment_base) & logical_match_mask) == 16'h0000; // RULE_16 RULE_07 RULE_08
    // Associative space compare under the space mask
    assign space_ok = ((task_space_number ^ desc_space_number) & space_number_mask) == 8'h00; // RULE_18 RULE_03
    assign hit      = seg_enable & range_ok & space_ok; // RULE_20
    // Base bits where mask is one, logical bits pass elsewhere
    assign phys_upper = (physical_segment_base & logical_match_mask) |
                        (logical_upper & ~logical_match_mask); // RULE_17

endmodule // sat_descriptor

// >>> bench/sat_translator_properties.sv
`timescale 1ns/100ps
// Port checks; a pin change reaches the outputs three edges later
module sat_translator_properties (
    input wire        clock,
    input wire        arst_n,
    input wire        cycle_strobe,
    input wire [23:1] logical_address,
    input wire [15:0] translated_upper_bits,
    input wire [6:0]  passthrough_low_bits,
    input wire        phys_valid,
    input wire        fault,
    input wire        irq_out,
    input wire        reg_read,
    input wire [15:0] reg_rdata
);
    reg  [1:0] up_cnt_r;
    wire       up_ok;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Edges since reset, so that $past never looks into reset
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            up_cnt_r <= 2'h0;
        else if (up_cnt_r != 2'h3)
            up_cnt_r <= up_cnt_r + 2'h1;
    end
    assign up_ok = (up_cnt_r == 2'h3);

    low_bypass_a: assert property (up_ok |-> passthrough_low_bits == $past(logical_address[7:1], 3))
        else $error("low address bits not passed through");
    idle_quiet_a: assert property (up_ok && !$past(cycle_strobe, 3) |->
        !phys_valid && !fault && translated_upper_bits == 16'h0000)
        else $error("outputs active without a bus cycle");
    one_answer_a: assert property (up_ok && $past(cycle_strobe, 3) |-> phys_valid != fault)
        else $error("bus cycle without exactly one of valid and fault");
    upper_zero_a: assert property (!phys_valid |-> translated_upper_bits == 16'h0000)
        else $error("upper bits shown without a good translation");
    answer_start_a: assert property (up_ok && $rose(cycle_strobe) |->
        ##2 (!phys_valid && !fault) ##1 (phys_valid || fault))
        else $error("answer not on the third edge after strobe");
    strobe_end_a: assert property (up_ok && $fell(cycle_strobe) |-> ##3 (!phys_valid && !fault))
        else $error("answer not withdrawn after strobe fell");
    rdata_pulse_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data outside the cycle after a read");
    reset_quiet_a: assert property (disable iff (1'b0) !arst_n |->
        !phys_valid && !fault && !irq_out && translated_upper_bits == 16'h0000)
        else $error("outputs active in reset");
endmodule // sat_translator_properties

// >>> bench/sat_cpu_model.sv
`timescale 1ns/100ps
// Bus master and memory side: one bus cycle at a time
module sat_cpu_model (
    input  wire        clock,
    input  wire [15:0] translated_upper_bits,
    input  wire [6:0]  passthrough_low_bits,
    input  wire        phys_valid,
    input  wire        fault,
    output reg         cycle_strobe,
    output reg         cycle_write,
    output reg  [2:0]  space_code_lines,
    output reg         fourth_space_code_line,
    output reg  [23:1] logical_address
);
    reg [24:0] got_r;

    // Idle bus at time zero
    initial begin
        cycle_strobe = 1'b0;
        cycle_write = 1'b0;
        space_code_lines = 3'h0;
        fourth_space_code_line = 1'b0;
        logical_address = 23'h000000;
        got_r = 25'h0000000;
    end

    // Pins held five edges; answer read after four, one past two sync flops and the output register
    task run_cycle(input [3:0] idx, input wr, input [23:1] la);
        begin
            @(posedge clock);
            cycle_strobe <= 1'b1;
            cycle_write <= wr;
            space_code_lines <= idx[2:0];
            fourth_space_code_line <= idx[3];
            logical_address <= la;
            repeat (4) @(posedge clock);
            #1;
            got_r = {phys_valid, fault, translated_upper_bits, passthrough_low_bits};
            @(posedge clock);
            cycle_strobe <= 1'b0;
            cycle_write <= ~wr;
            space_code_lines <= ~idx[2:0];
            fourth_space_code_line <= 1'b0;
            logical_address <= ~la; // Released bus does not keep its last value
            repeat (4) @(posedge clock);
        end
    endtask
endmodule // sat_cpu_model

// >>> bench/sat_translator_tb_top.sv
`timescale 1ns/100ps
`include "sat_consts.vh"
// Register and bus-cycle scenarios for the translator
module sat_translator_tb_top;
    reg         clock;
    reg         arst_n;
    reg  [7:0]  reg_addr;
    reg  [15:0] reg_wdata;
    reg         reg_write;
    reg         reg_read;
    wire [15:0] reg_rdata;
    wire [15:0] upper;
    wire [6:0]  low;
    wire [23:1] la;
    wire [2:0]  fc;
    wire        strobe, wr, fc3, valid, fault, irq_out;
    integer     error_cnt;
    integer     n_checks;
    integer     i;

    sat_translator dut_u (.clock(clock), .arst_n(arst_n), .cycle_strobe(strobe),
        .cycle_write(wr), .space_code_lines(fc), .fourth_space_code_line(fc3),
        .logical_address(la), .translated_upper_bits(upper), .passthrough_low_bits(low),
        .phys_valid(valid), .fault(fault), .irq_out(irq_out), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata));
    sat_cpu_model cpu_u (.clock(clock), .translated_upper_bits(upper),
        .passthrough_low_bits(low), .phys_valid(valid), .fault(fault), .cycle_strobe(strobe),
        .cycle_write(wr), .space_code_lines(fc), .fourth_space_code_line(fc3),
        .logical_address(la));

    // 250 MHz
    always #2 clock = ~clock;

    task finish_test;
        begin
            if (error_cnt == 0 && n_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task chk_reg(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR t=%0t reg got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task chk_pin(input [24:0] got, input [24:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR t=%0t pins got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task reg_wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= 1'b1;
            @(posedge clock);
            reg_write <= 1'b0;
        end
    endtask

    // Read data stand only in the cycle after the strobe
    task rd_chk(input [7:0] a, input [15:0] exp);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge clock);
            reg_read <= 1'b0;
            #1;
            chk_reg(reg_rdata, exp);
        end
    endtask

    // One bus cycle; a miss must show fault and zero upper bits
    task acc(input [3:0] idx, input w, input [23:0] a, input ev, input [15:0] eup);
        begin
            cpu_u.run_cycle(idx, w, a[23:1]);
            chk_pin(cpu_u.got_r, {ev, ~ev, ev ? eup : 16'h0000, a[7:1]});
        end
    endtask

    // Hang guard
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        finish_test;
    end

    initial begin
        clock = 1'b0;
        arst_n <= 1'b0; // Lands after every reset process waits
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        // Reset image: descriptor 0 maps everything one to one
        rd_chk(`SAT_OFF_STATUS, 16'h0001);
        acc(4'h1, 1'b0, 24'habcdef, 1'b1, 16'habcd);
        for (i = 0; i < 16; i = i + 1) begin
            reg_wr(`SAT_OFF_SPACE_BASE + i[7:0], 16'h0010 + i[15:0]);
            rd_chk(`SAT_OFF_SPACE_BASE + i[7:0], 16'h0010 + i[15:0]);
        end
        reg_wr(`SAT_OFF_STATUS, 16'h0000);
        acc(4'h5, 1'b0, 24'h12abcd, 1'b0, 16'h0000);
        // Descriptor 1: 4 KB in space 0x15; descriptor 2: all 16 MB, space 0x1d, protected
        reg_wr(`SAT_OFF_DPTR, 16'h0001);
        reg_wr(`SAT_OFF_LBASE, 16'h12a0);
        reg_wr(`SAT_OFF_LMASK, 16'hfff0);
        reg_wr(`SAT_OFF_PBASE, 16'h34c0);
        reg_wr(`SAT_OFF_SPACE_NUM, 16'hff15);
        reg_wr(`SAT_OFF_STATUS, 16'h0001);
        reg_wr(`SAT_OFF_DPTR, 16'h0002);
        reg_wr(`SAT_OFF_SPACE_NUM, 16'hff1d);
        reg_wr(`SAT_OFF_STATUS, 16'h0003);
        rd_chk(`SAT_OFF_SPACE_NUM, 16'hff1d);
        rd_chk(`SAT_OFF_DPTR, 16'h0002);
        acc(4'h5, 1'b0, 24'h12abcd, 1'b1, 16'h34cb);
        acc(4'h5, 1'b1, 24'h12a000, 1'b1, 16'h34c0);
        acc(4'h5, 1'b0, 24'h12afff, 1'b1, 16'h34cf);
        acc(4'h5, 1'b0, 24'h12b000, 1'b0, 16'h0000);
        acc(4'h6, 1'b0, 24'h12abcd, 1'b0, 16'h0000);
        acc(4'hd, 1'b0, 24'hfedcba, 1'b1, 16'hfedc);
        acc(4'hd, 1'b1, 24'hfedcba, 1'b0, 16'h0000);
        rd_chk(`SAT_OFF_STATUS, 16'h0083);
        reg_wr(`SAT_OFF_DPTR, 16'h0001);
        rd_chk(`SAT_OFF_STATUS, 16'h0085);
        rd_chk(`SAT_OFF_LBASE, 16'h12a0);
        rd_chk(`SAT_OFF_LMASK, 16'hfff0);
        rd_chk(`SAT_OFF_PBASE, 16'h34c0);
        // Interrupt on access, then masked, then cleared
        reg_wr(`SAT_OFF_STATUS, 16'h0011);
        reg_wr(`SAT_OFF_GLOBAL, 16'h0004);
        acc(4'h5, 1'b0, 24'h12a100, 1'b1, 16'h34c1);
        chk_pin({24'h000000, irq_out}, 25'h0000001);
        rd_chk(`SAT_OFF_STATUS, 16'h0099);
        reg_wr(`SAT_OFF_GLOBAL, 16'h0000);
        repeat (3) @(posedge clock);
        chk_pin({24'h000000, irq_out}, 25'h0000000);
        reg_wr(`SAT_OFF_STATUS, 16'h00f1);
        rd_chk(`SAT_OFF_STATUS, 16'h0091);
        reg_wr(`SAT_OFF_GLOBAL, 16'h0004);
        repeat (3) @(posedge clock);
        chk_pin({24'h000000, irq_out}, 25'h0000000);
        // Direct translation, hit then miss
        reg_wr(`SAT_OFF_TR_SPACE, 16'h0015);
        reg_wr(`SAT_OFF_TR_ADDR, 16'h12ab);
        rd_chk(`SAT_OFF_TR_RESULT, 16'h34cb);
        rd_chk(`SAT_OFF_GLOBAL, 16'h0007);
        reg_wr(`SAT_OFF_TR_ADDR, 16'h13ab);
        rd_chk(`SAT_OFF_GLOBAL, 16'h0005);
        rd_chk(`SAT_OFF_TR_RESULT, 16'h0000);
        rd_chk(`SAT_OFF_TR_ADDR, 16'h13ab);
        rd_chk(`SAT_OFF_TR_SPACE, 16'h0015);
        rd_chk(8'h40, 16'h0000);
        // Reset in mid-run restores the reset image
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        rd_chk(`SAT_OFF_STATUS, 16'h0001);
        rd_chk(8'h05, 16'h0000);
        finish_test;
    end
endmodule // sat_translator_tb_top

bind sat_translator sat_translator_properties chk_u (.clock(clock), .arst_n(arst_n),
    .cycle_strobe(cycle_strobe), .logical_address(logical_address),
    .translated_upper_bits(translated_upper_bits), .passthrough_low_bits(passthrough_low_bits),
    .phys_valid(phys_valid), .fault(fault), .irq_out(irq_out), .reg_read(reg_read),
    .reg_rdata(reg_rdata));
